// File: logic/oto_pkg.sv
// Shared constants for the output test override block.
package oto_pkg;

   // Channel counts.
   localparam int N_RELAY = 4;
   localparam int N_AO    = 4;

   // Relay force setting codes.
   localparam logic [1:0] FRC_OFF     = 2'h0;
   localparam logic [1:0] FRC_ENERG   = 2'h1;
   localparam logic [1:0] FRC_DEENERG = 2'h2;

   // Relay force duration, in whole seconds; zero means static.
   localparam logic [8:0] DUR_STATIC = 9'h000;
   localparam logic [8:0] DUR_MAX    = 9'h12c;

   // Analog force percentage; zero means off.
   localparam logic [6:0] PCT_OFF = 7'h00;
   localparam logic [6:0] PCT_MAX = 7'h64;

   // Analog current range codes and output codes in microamps.
   localparam logic [1:0]  RNG_0_1   = 2'h0;
   localparam logic [1:0]  RNG_0_20  = 2'h1;
   localparam logic [1:0]  RNG_4_20  = 2'h2;
   localparam logic [15:0] LO_4_20   = 16'h0fa0;
   localparam logic [15:0] STEP_0_1  = 16'h000a;
   localparam logic [15:0] STEP_0_20 = 16'h00c8;
   localparam logic [15:0] STEP_4_20 = 16'h00a0;
   localparam logic [15:0] FS_1MA    = 16'h03e8;
   localparam logic [15:0] FS_20MA   = 16'h4e20;

   // Reactive power scaling limits in kvar.
   localparam logic signed [15:0] VAR_LO = 16'sh8300;
   localparam logic signed [15:0] VAR_HI = 16'sh7d00;

   // Register byte offsets.
   localparam logic [7:0] OFS_FORCE  = 8'h00;
   localparam logic [7:0] OFS_DUR0   = 8'h04;
   localparam logic [7:0] OFS_AOF0   = 8'h14;
   localparam logic [7:0] OFS_RANGE  = 8'h24;
   localparam logic [7:0] OFS_STATUS = 8'h28;
   localparam logic [7:0] OFS_SCALE0 = 8'h2c;
   localparam logic [7:0] OFS_END    = 8'h3c;

   // Register kinds produced by the address decoder.
   localparam logic [2:0] K_NONE  = 3'h0;
   localparam logic [2:0] K_FRC   = 3'h1;
   localparam logic [2:0] K_DUR   = 3'h2;
   localparam logic [2:0] K_AOF   = 3'h3;
   localparam logic [2:0] K_RNG   = 3'h4;
   localparam logic [2:0] K_STAT  = 3'h5;
   localparam logic [2:0] K_SCL   = 3'h6;

   // Bus responses.
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // One-second timebase.
   localparam int SECOND_NS     = 1000000000;
   localparam int CLK_PERIOD_NS = 8;
   localparam int CYC_PER_SEC   = SECOND_NS / CLK_PERIOD_NS;

endpackage

// File: logic/oto_mem.sv
// Small register-read memory holding the analog force percentages.
`timescale 1ns/1ps
module oto_mem #(
   parameter int DEPTH = 4,
   parameter int WIDTH = 7
) (
   input  wire logic                     clock,
   input  wire logic                     rst_b,
   input  wire logic                     wr_en,
   input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
   input  wire logic [WIDTH-1:0]         wr_data,
   input  wire logic [$clog2(DEPTH)-1:0] ra_addr,
   output logic      [WIDTH-1:0]         ra_data,
   input  wire logic [$clog2(DEPTH)-1:0] rb_addr,
   output logic      [WIDTH-1:0]         rb_data
);

   logic [DEPTH-1:0][WIDTH-1:0] mem_ff;

   if (DEPTH < 2) $error("oto_mem needs a depth of at least two");

   // Contents clear on reset so every channel powers up with no force.
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         mem_ff  <= '0;
         ra_data <= '0;
         rb_data <= '0;
      end
      else
      begin
         if (wr_en)
         begin
            mem_ff[wr_addr] <= wr_data;
         end
         ra_data <= mem_ff[ra_addr];
         rb_data <= mem_ff[rb_addr];
      end
   end

endmodule

// File: logic/oto_output_test_override.sv
// Output test override: relay forces with timers and analog output forces.
`timescale 1ns/1ps
module oto_output_test_override #(
   parameter int ADDR_W     = 8,
   parameter int SEC_CYCLES = oto_pkg::CYC_PER_SEC
) (
   input  wire logic              clock,
   input  wire logic              rst_b,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic [3:0]        normal_relay,
   output logic [3:0]             relay_drive,
   output logic [3:0]             relay_led,
   output logic                   in_service_led,
   input  wire logic [63:0]       norm_code,
   output logic [63:0]            ao_code,
   output logic [127:0]           scale_lim
);
   import oto_pkg::*;

   localparam int PW = $clog2(SEC_CYCLES);

   if (SEC_CYCLES < 2) $error("SEC_CYCLES must be at least two");
   if (ADDR_W < 8) $error("ADDR_W must be at least eight");

   typedef struct packed {
      logic [3:0][1:0]    frc;
      logic [3:0][8:0]    dur;
      logic [3:0][PW-1:0] presc;
      logic [3:0][8:0]    secs;
      logic [3:0]         expired;
      logic [3:0][1:0]    rng;
      logic [3:0][31:0]   scale;
      logic               aw_got;
      logic               w_got;
      logic [ADDR_W-1:0]  waddr;
      logic [31:0]        wdata;
      logic [3:0]         wstrb;
      logic               awready;
      logic               wready;
      logic               bvalid;
      logic [1:0]         bresp;
      logic               arready;
      logic               rd_pend;
      logic               rvalid;
      logic [ADDR_W-1:0]  raddr;
      logic [31:0]        rdata;
      logic [1:0]         rresp;
      logic [1:0]         scan;
      logic [1:0]         scan_d;
      logic [3:0]         drive;
      logic [3:0]         led;
      logic               svc;
      logic [3:0][15:0]   ao;
   } oto_state_s;

   oto_state_s st_ff;
   oto_state_s nxt_st;

   logic [4:0]  wdec;
   logic [4:0]  rdec;
   logic [4:0]  ardec;
   logic        wexec;
   logic        mem_we;
   logic [6:0]  mem_ra;
   logic [6:0]  mem_rb;
   logic [3:0]  restart;
   logic [3:0]  active;
   logic [31:0] mrg;
   logic [15:0] norm_sel;

   // Maps an address to a register kind and channel index; upper bits must be zero.
   function automatic logic [4:0] decode(input logic [ADDR_W-1:0] a);
      logic [7:0] w;
      logic [7:0] rel;
      w   = a[7:0];
      rel = 8'h00;
      decode = {K_NONE, 2'h0};
      if ((a >> 8) == '0)
      begin
         if (w[7:2] == OFS_FORCE[7:2])
         begin
            decode = {K_FRC, 2'h0};
         end
         else if (w >= OFS_DUR0 && w < OFS_AOF0)
         begin
            rel    = w - OFS_DUR0;
            decode = {K_DUR, rel[3:2]};
         end
         else if (w >= OFS_AOF0 && w < OFS_RANGE)
         begin
            rel    = w - OFS_AOF0;
            decode = {K_AOF, rel[3:2]};
         end
         else if (w[7:2] == OFS_RANGE[7:2])
         begin
            decode = {K_RNG, 2'h0};
         end
         else if (w[7:2] == OFS_STATUS[7:2])
         begin
            decode = {K_STAT, 2'h0};
         end
         else if (w >= OFS_SCALE0 && w < OFS_END)
         begin
            rel    = w - OFS_SCALE0;
            decode = {K_SCL, rel[3:2]};
         end
      end
   endfunction

   // Replaces the byte lanes whose strobe is set.
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      merge = old;
      for (int b = 0; b < 4; b++)
      begin
         if (strb[b])
         begin
            merge[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
   endfunction

   // The spare force code is taken as disabled, so no relay can be left half forced.
   function automatic logic [1:0] fix_force(input logic [1:0] v);
      fix_force = (v == FRC_ENERG || v == FRC_DEENERG) ? v : FRC_OFF;
   endfunction

   // Durations past the longest allowed saturate rather than wrap to a short one.
   function automatic logic [8:0] fix_dur(input logic [31:0] v);
      fix_dur = (v > 32'(DUR_MAX)) ? DUR_MAX : v[8:0];
   endfunction

   // Percentages past full scale saturate at full scale.
   function automatic logic [6:0] fix_pct(input logic [7:0] v);
      fix_pct = (v > 8'(PCT_MAX)) ? PCT_MAX : v[6:0];
   endfunction

   // The spare range code is taken as the low current range.
   function automatic logic [1:0] fix_rng(input logic [1:0] v);
      fix_rng = (v == RNG_0_20 || v == RNG_4_20) ? v : RNG_0_1;
   endfunction

   // Clamps a signed scaling limit to the reactive power span.
   function automatic logic [15:0] fix_lim(input logic [15:0] v);
      if ($signed(v) > VAR_HI)
      begin
         fix_lim = VAR_HI;
      end
      else if ($signed(v) < VAR_LO)
      begin
         fix_lim = VAR_LO;
      end
      else
      begin
         fix_lim = v;
      end
   endfunction

   // Forced output code in microamps; the step per percent avoids any divider.
   function automatic logic [15:0] ao_forced(input logic [1:0] r, input logic [6:0] p);
      logic [15:0] p16;
      p16 = {9'h000, p};
      unique case (r)
         RNG_0_1:  ao_forced = 16'(p16 * STEP_0_1);
         RNG_0_20: ao_forced = 16'(p16 * STEP_0_20);
         default:  ao_forced = 16'(LO_4_20 + p16 * STEP_4_20);
      endcase
   endfunction

   // Address decodes for the pending write, the pending read and the incoming read.
   assign wdec   = decode(st_ff.waddr);
   assign rdec   = decode(st_ff.raddr);
   assign ardec  = decode(s_axi_araddr);
   assign wexec  = st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;
   assign mem_we = wexec && wdec[4:2] == K_AOF && st_ff.wstrb[0];

   // Analog force percentages: port a is scanned, port b serves bus reads.
   oto_mem #(
      .DEPTH (N_AO),
      .WIDTH (7)
   ) u_aof (
      .clock   (clock),
      .rst_b   (rst_b),
      .wr_en   (mem_we),
      .wr_addr (wdec[1:0]),
      .wr_data (fix_pct(st_ff.wdata[7:0])),
      .ra_addr (st_ff.scan),
      .ra_data (mem_ra),
      .rb_addr (ardec[1:0]),
      .rb_data (mem_rb)
   );

   // A force holds while set and either static or not yet timed out.
   always_comb
   begin
      for (int i = 0; i < N_RELAY; i++)
      begin
         active[i] = st_ff.frc[i] != FRC_OFF &&
                     (st_ff.dur[i] == DUR_STATIC || !st_ff.expired[i]);
      end
   end

   assign norm_sel = norm_code[st_ff.scan_d*16 +: 16];

   // Next state: bus slave, timers, relay override and analog scan.
   always_comb
   begin
      nxt_st  = st_ff;
      restart = 4'h0;
      mrg     = 32'h0000_0000;
      if (s_axi_awvalid && st_ff.awready)
      begin
         nxt_st.aw_got = 1'b1;
         nxt_st.waddr  = s_axi_awaddr;
      end
      if (s_axi_wvalid && st_ff.wready)
      begin
         nxt_st.w_got = 1'b1;
         nxt_st.wdata = s_axi_wdata;
         nxt_st.wstrb = s_axi_wstrb;
      end
      if (st_ff.bvalid && s_axi_bready)
      begin
         nxt_st.bvalid = 1'b0;
      end
      if (wexec)
      begin
         nxt_st.aw_got = 1'b0;
         nxt_st.w_got  = 1'b0;
         nxt_st.bvalid = 1'b1;
         nxt_st.bresp  = RESP_OKAY;
         unique case (wdec[4:2])
            K_FRC:
            begin
               mrg = merge({24'h0, st_ff.frc}, st_ff.wdata, st_ff.wstrb);
               for (int i = 0; i < N_RELAY; i++)
               begin
                  nxt_st.frc[i] = fix_force(mrg[i*2 +: 2]);
                  restart[i]    = st_ff.wstrb[0] && nxt_st.frc[i] != FRC_OFF;
               end
            end
            K_DUR:
            begin
               mrg = merge({23'h0, st_ff.dur[wdec[1:0]]}, st_ff.wdata, st_ff.wstrb);
               nxt_st.dur[wdec[1:0]] = fix_dur(mrg);
               restart[wdec[1:0]]    = st_ff.wstrb != 4'h0;
            end
            K_RNG:
            begin
               mrg = merge({24'h0, st_ff.rng}, st_ff.wdata, st_ff.wstrb);
               for (int i = 0; i < N_AO; i++)
               begin
                  nxt_st.rng[i] = fix_rng(mrg[i*2 +: 2]);
               end
            end
            K_SCL:
            begin
               mrg = merge(st_ff.scale[wdec[1:0]], st_ff.wdata, st_ff.wstrb);
               nxt_st.scale[wdec[1:0]] = {fix_lim(mrg[31:16]), fix_lim(mrg[15:0])};
            end
            K_AOF, K_STAT:
            begin
               nxt_st.bresp = RESP_OKAY;
            end
            default:
            begin
               nxt_st.bresp = RESP_SLVERR;
            end
         endcase
      end

      // Read answer one edge after the address is taken, once port b has the data.
      if (s_axi_arvalid && st_ff.arready)
      begin
         nxt_st.rd_pend = 1'b1;
         nxt_st.raddr   = s_axi_araddr;
      end
      if (st_ff.rvalid && s_axi_rready)
      begin
         nxt_st.rvalid = 1'b0;
      end
      if (st_ff.rd_pend)
      begin
         nxt_st.rd_pend = 1'b0;
         nxt_st.rvalid  = 1'b1;
         nxt_st.rresp   = RESP_OKAY;
         nxt_st.rdata   = 32'h0000_0000;
         unique case (rdec[4:2])
            K_FRC:   nxt_st.rdata = {24'h0, st_ff.frc};
            K_DUR:   nxt_st.rdata = {23'h0, st_ff.dur[rdec[1:0]]};
            K_AOF:   nxt_st.rdata = {25'h0, mem_rb};
            K_RNG:   nxt_st.rdata = {24'h0, st_ff.rng};
            K_STAT:  nxt_st.rdata = {23'h0, st_ff.svc, active, st_ff.drive};
            K_SCL:   nxt_st.rdata = st_ff.scale[rdec[1:0]];
            default: nxt_st.rresp = RESP_SLVERR;
         endcase
      end

      // Ready drops while a request is held, so each channel takes one at a time.
      nxt_st.awready = !nxt_st.aw_got && !nxt_st.bvalid;
      nxt_st.wready  = !nxt_st.w_got && !nxt_st.bvalid;
      nxt_st.arready = !nxt_st.rd_pend && !nxt_st.rvalid;

      // Per-relay one-second prescaler and seconds count for timed forces.
      for (int i = 0; i < N_RELAY; i++)
      begin
         if (restart[i])
         begin
            nxt_st.presc[i]   = '0;
            nxt_st.secs[i]    = 9'h000;
            nxt_st.expired[i] = 1'b0;
         end
         else if (st_ff.frc[i] != FRC_OFF && st_ff.dur[i] != DUR_STATIC && !st_ff.expired[i])
         begin
            if (st_ff.presc[i] == PW'(SEC_CYCLES - 1))
            begin
               nxt_st.presc[i] = '0;
               nxt_st.secs[i]  = st_ff.secs[i] + 9'h001;
               if (nxt_st.secs[i] == st_ff.dur[i])
               begin
                  nxt_st.expired[i] = 1'b1;
               end
            end
            else
            begin
               nxt_st.presc[i] = st_ff.presc[i] + PW'(1);
            end
         end
      end

      // Relay override; an expired force still counts for test mode until disabled.
      for (int i = 0; i < N_RELAY; i++)
      begin
         nxt_st.drive[i] = active[i] ? st_ff.frc[i] == FRC_ENERG : normal_relay[i];
         nxt_st.led[i]   = nxt_st.drive[i];
      end
      nxt_st.svc = st_ff.frc != '0;

      // One analog channel refreshed per cycle, so each lags its source by a few cycles.
      nxt_st.scan   = st_ff.scan + 2'h1;
      nxt_st.scan_d = st_ff.scan;
      if (mem_ra != PCT_OFF)
      begin
         nxt_st.ao[st_ff.scan_d] = ao_forced(st_ff.rng[st_ff.scan_d], mem_ra);
      end
      else
      begin
         nxt_st.ao[st_ff.scan_d] = norm_sel;
      end
   end

   // Loss of power is the reset: every force, timer and override clears.
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st_ff <= '0;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   // Every output is a field of the registered state.
   assign s_axi_awready  = st_ff.awready;
   assign s_axi_wready   = st_ff.wready;
   assign s_axi_bresp    = st_ff.bresp;
   assign s_axi_bvalid   = st_ff.bvalid;
   assign s_axi_arready  = st_ff.arready;
   assign s_axi_rdata    = st_ff.rdata;
   assign s_axi_rresp    = st_ff.rresp;
   assign s_axi_rvalid   = st_ff.rvalid;
   assign relay_drive    = st_ff.drive;
   assign relay_led      = st_ff.led;
   assign in_service_led = st_ff.svc;
   assign ao_code        = st_ff.ao;
   assign scale_lim      = st_ff.scale;

   // Checks on the registered behaviour, all on the one clock.
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);

   force_codes_a: assert property (st_ff.frc[0] != 2'h3 && st_ff.frc[1] != 2'h3 &&
                                   st_ff.frc[2] != 2'h3 && st_ff.frc[3] != 2'h3)
      else $error("relay force holds the spare code");
   dur_limit_a: assert property (st_ff.dur[0] <= DUR_MAX && st_ff.dur[1] <= DUR_MAX &&
                                 st_ff.dur[2] <= DUR_MAX && st_ff.dur[3] <= DUR_MAX)
      else $error("relay duration above the longest allowed");
   test_mode_a: assert property ((st_ff.frc != '0) [*2] |-> in_service_led)
      else $error("in-service indicator off while a force is set");
   status_led_a: assert property (relay_led == relay_drive)
      else $error("status indicator differs from relay drive");
   pct_limit_a: assert property (mem_ra <= PCT_MAX)
      else $error("analog force percentage above full scale");
   full_scale_a: assert property (mem_ra == PCT_MAX && st_ff.rng[st_ff.scan_d] == RNG_4_20
                                  |=> st_ff.ao[$past(st_ff.scan_d)] == FS_20MA)
      else $error("full scale force not at top of range");
   normal_ao_a: assert property (mem_ra == PCT_OFF
                                 |=> st_ff.ao[$past(st_ff.scan_d)] == $past(norm_sel))
      else $error("unforced analog output not following its source");

   for (genvar g = 0; g < N_RELAY; g++)
   begin : g_chk
      forced_drive_a: assert property (active[g]
                                       |=> relay_drive[g] == $past(st_ff.frc[g] == FRC_ENERG))
         else $error("forced relay not in its forced state");
      expired_release_a: assert property (st_ff.frc[g] != FRC_OFF && st_ff.expired[g] &&
                                          st_ff.dur[g] != DUR_STATIC
                                          |=> relay_drive[g] == $past(normal_relay[g]))
         else $error("expired force still overriding relay");
      static_hold_a: assert property (st_ff.dur[g] == DUR_STATIC |-> !st_ff.expired[g])
         else $error("static force has timed out");
      timer_restart_a: assert property (restart[g]
                                        |=> st_ff.secs[g] == 9'h000 && !st_ff.expired[g])
         else $error("timer not restarted by a settings write");
      var_limit_a: assert property ($signed(st_ff.scale[g][15:0]) >= VAR_LO &&
                                    $signed(st_ff.scale[g][31:16]) <= VAR_HI)
         else $error("scaling limit outside reactive span");
   end

endmodule

// File: testbench/oto_far_model.sv
// Far side model: protection logic feeding normal states, and the relay coils.
`timescale 1ns/1ps
module oto_far_model (
   input  wire logic        clock,
   input  wire logic        rst_b,
   input  wire logic [3:0]  prot_state,
   input  wire logic [63:0] prot_code,
   input  wire logic [3:0]  relay_drive,
   output logic      [3:0]  normal_relay,
   output logic      [63:0] norm_code,
   output logic      [3:0]  coil_on
);
   // Protection decisions arrive registered, as a real pipeline delivers them.
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         normal_relay <= 4'h0;
         norm_code    <= 64'h0;
      end
      else
      begin
         normal_relay <= prot_state;
         norm_code    <= prot_code;
      end
   end
   // Coils follow the drive at once; a slow driver would only add delay.
   assign coil_on = relay_drive;
endmodule

// File: testbench/tb_oto_output_test_override.sv
// Self-checking bench for the output test override block.
`timescale 1ns/1ps
module tb_oto_output_test_override;
   import oto_pkg::*;
   logic         clock = 1'b0;
   logic         rst_b = 1'b0;
   logic [7:0]   awaddr = 8'h00, araddr = 8'h00;
   logic         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0]  wdata = 32'h0, d, rdata_w;
   logic [1:0]   bresp, rresp, resp;
   logic         awready, wready, bvalid, arready, rvalid, isl;
   logic [3:0]   prot = 4'h0, nrel, drive, led, e;
   logic [63:0]  pcode = 64'h0, ncode, ao;
   logic [127:0] lim;
   int           failures = 0, tests_run = 0;

   // Free-running 125 MHz clock.
   always #4 clock = ~clock;

   oto_output_test_override #(.ADDR_W(8), .SEC_CYCLES(8)) i_oto_output_test_override (
      .clock(clock), .rst_b(rst_b), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata_w),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .normal_relay(nrel), .relay_drive(drive), .relay_led(led), .in_service_led(isl),
      .norm_code(ncode), .ao_code(ao), .scale_lim(lim));

   oto_far_model i_oto_far_model (.clock(clock), .rst_b(rst_b), .prot_state(prot),
      .prot_code(pcode), .relay_drive(drive), .normal_relay(nrel), .norm_code(ncode),
      .coil_on());

   task automatic stop_test;
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask

   // Write with both channels offered together; each is dropped once taken.
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      int n;
      n = 0;
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge clock);
         n++;
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
      end
      while (!bvalid && n < 50);
      resp = bresp;
      bready <= 1'b0;
      // One idle edge, so a following call never raises bready in the step it was lowered.
      @(posedge clock);
      if (n >= 50)
      begin
         failures++;
         stop_test();
      end
   endtask

   task automatic rd(input logic [7:0] a);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge clock);
         n++;
         if (arready)
            arvalid <= 1'b0;
      end
      while (!rvalid && n < 50);
      d = rdata_w;
      resp = rresp;
      rready <= 1'b0;
      // One idle edge, so a following call never raises rready in the step it was lowered.
      @(posedge clock);
      if (n >= 50)
      begin
         failures++;
         stop_test();
      end
   endtask

   function automatic logic [15:0] ao_exp(input logic [1:0] r, input logic [6:0] p);
      if (r == RNG_4_20)
         return LO_4_20 + 16'(p) * STEP_4_20;
      return 16'(p) * ((r == RNG_0_20) ? STEP_0_20 : STEP_0_1);
   endfunction

   // Main sequence; timed forces use a prescaler of 8 cycles per second.
   initial
   begin
      int r, c, dur;
      r = $urandom(32'h894a);
      repeat (3) @(posedge clock);
      rst_b <= 1'b1;
      cyc(2);
      chk(64'(drive), 64'(nrel));
      wr(8'h3c, 32'h1);
      chk(64'(resp), 64'(RESP_SLVERR));
      rd(8'h3c);
      chk(64'({resp, d}), 64'({RESP_SLVERR, 32'h0}));
      wr(OFS_DUR0, 32'h3e7);
      rd(OFS_DUR0);
      chk(64'(d), 64'(DUR_MAX));
      for (r = 0; r < 4; r++)
         for (c = 1; c < 3; c++)
         begin
            prot <= 4'($urandom);
            dur = (r == c) ? 0 : 2 + $urandom % 2;
            wr(OFS_DUR0 + 8'(4 * r), 32'(dur));
            wr(OFS_FORCE, 32'(c) << (2 * r));
            cyc(3);
            e = nrel;
            e[r] = (c == 1);
            chk(64'(drive), 64'(e));
            chk(64'(led), 64'(e));
            chk(64'(isl), 64'h1);
            cyc((dur == 0) ? 40 : dur * 8 + 5);
            e[r] = (dur == 0) ? (c == 1) : nrel[r];
            chk(64'(drive), 64'(e));
            chk(64'(isl), 64'h1);
            wr(OFS_FORCE, 32'h0);
            cyc(2);
            chk(64'(isl), 64'h0);
         end
      // A rewrite part way through a timed force must restart its count.
      // Normal states are all energized, so only a working force shows de-energized.
      prot <= 4'hf;
      wr(OFS_DUR0 + 8'h08, 32'h2);
      wr(OFS_FORCE, 32'h20);
      cyc(10);
      wr(OFS_FORCE, 32'h20);
      cyc(10);
      chk(64'(drive[2]), 64'h0);
      wr(OFS_FORCE, 32'haa);
      cyc(3);
      chk(64'(drive), 64'h0);
      rst_b <= 1'b0;
      cyc(3);
      rst_b <= 1'b1;
      cyc(3);
      chk(64'({drive, 3'h0, isl}), 64'({nrel, 4'h0}));
      rd(OFS_FORCE);
      chk(64'(d), 64'h0);
      pcode <= {$urandom, $urandom};
      for (c = 0; c < 4; c++)
      begin
         r = c % 3;
         // Channel two runs full scale on the 4-20 mA range as a corner case.
         dur = (c == 2) ? 100 : 1 + $urandom % 100;
         wr(OFS_RANGE, 32'(r) << (2 * c));
         wr(OFS_AOF0 + 8'(4 * c), 32'(dur));
         cyc(6);
         chk(64'(ao[16*c+:16]), 64'(ao_exp(2'(r), 7'(dur))));
         wr(OFS_AOF0 + 8'(4 * c), 32'h0);
         cyc(6);
         chk(64'(ao[16*c+:16]), 64'(ncode[16*c+:16]));
      end
      wr(OFS_SCALE0, 32'h7fff8000);
      rd(OFS_SCALE0);
      chk(64'(d), 64'({VAR_HI, VAR_LO}));
      chk(64'(lim[31:0]), 64'({VAR_HI, VAR_LO}));
      stop_test();
   end
endmodule
